// ---- rtl/i2c_master_timing_base.sv ----
// i2c_master_timing_base: tick dividers, boot shadows and start/stop/idle sequencing
`timescale 1ns/1ps
`default_nettype none
module i2c_master_timing_base (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // boot loader status
  input  wire logic        boot_active,
  // controller requests and answers
  input  wire logic        start_req,
  input  wire logic        stop_req,
  output var  logic        start_done,
  output var  logic        stop_done,
  output var  logic        bus_idle,
  output var  logic        us_tick,
  output var  logic        ms_tick,
  // serial clock pin, open drain
  input  wire logic        scl_in,
  output var  logic        scl_out,
  output var  logic        scl_oe,
  // serial_data_line pin, open drain
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe
);

  timing_pkg::timing_cfg_t live_r;
  timing_pkg::timing_cfg_t shadow_r;
  timing_pkg::bus_state_t  state_r;
  timing_pkg::bus_state_t  state_nxt;

  logic        phase_load_r;
  logic        us_tick_w;
  logic        ms_tick_w;
  logic        phase_tick;
  logic        phase_cond;
  logic [15:0] phase_count;
  logic        phase_done;
  logic        wr_div;
  logic        wr_start;
  logic        wr_stop;

  // field accessors
  function automatic logic [15:0] lo_field(input logic [31:0] w);
    lo_field = w[timing_pkg::LO_LSB +: timing_pkg::FIELD_W];
  endfunction : lo_field

  function automatic logic [15:0] hi_field(input logic [31:0] w);
    hi_field = w[timing_pkg::HI_LSB +: timing_pkg::FIELD_W];
  endfunction : hi_field

  function automatic logic [31:0] pack_pair(input logic [15:0] lo, input logic [15:0] hi);
    pack_pair = {hi, lo};
  endfunction : pack_pair

  // write decode
  assign wr_div   = reg_wr && (reg_addr == timing_pkg::OFF_DIVIDER);
  assign wr_start = reg_wr && (reg_addr == timing_pkg::OFF_START);
  assign wr_stop  = reg_wr && (reg_addr == timing_pkg::OFF_STOP_IDLE);

  // software-visible timing registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      live_r <= timing_pkg::CFG_RESET;
    end else begin
      if (wr_div) begin
        live_r.microsecond_divider <= lo_field(reg_wdata);
        live_r.millisecond_divider <= hi_field(reg_wdata);
      end
      if (wr_start) begin
        live_r.start_setup <= lo_field(reg_wdata);
        live_r.start_hold  <= hi_field(reg_wdata);
      end
      if (wr_stop) begin
        live_r.stop_setup            <= lo_field(reg_wdata);
        live_r.bus_idle_detect_count <= hi_field(reg_wdata);
      end
    end
  end

  // working copy used by the bus, frozen while booting
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      shadow_r <= timing_pkg::CFG_RESET;
    end else begin
      if (!boot_active) begin
        shadow_r.microsecond_divider   <= live_r.microsecond_divider;
        shadow_r.millisecond_divider   <= live_r.millisecond_divider;
        shadow_r.bus_idle_detect_count <= live_r.bus_idle_detect_count;
      end
      if (!boot_active) begin
        shadow_r.start_setup <= live_r.start_setup;
        shadow_r.start_hold  <= live_r.start_hold;
        shadow_r.stop_setup  <= live_r.stop_setup;
      end
    end
  end

  tick_divider u_us_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .en      (1'b1),
    .div     (shadow_r.microsecond_divider),
    .tick_r  (us_tick_w)
  );

  tick_divider u_ms_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .en      (us_tick_w),
    .div     (shadow_r.millisecond_divider),
    .tick_r  (ms_tick_w)
  );

  // tick outputs registered once more
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      us_tick <= us_tick_w;
      ms_tick <= ms_tick_w;
    end
  end

  // per-phase tick, level condition and count
  always_comb begin
    phase_tick  = 1'b1;
    phase_cond  = 1'b1;
    phase_count = timing_pkg::COUNT_ZERO;
    unique case (state_r)
      timing_pkg::ST_RESET_IDLE: begin
        phase_tick  = us_tick_w;
        phase_cond  = scl_in;
        phase_count = shadow_r.bus_idle_detect_count;
      end
      timing_pkg::ST_IDLE_CHECK: begin
        phase_tick  = us_tick_w;
        phase_cond  = scl_in && sda_in;
        phase_count = shadow_r.bus_idle_detect_count;
      end
      timing_pkg::ST_START_SETUP: begin
        phase_cond  = scl_in && sda_in;
        phase_count = shadow_r.start_setup;
      end
      timing_pkg::ST_START_HOLD: begin
        phase_cond  = !sda_in;
        phase_count = shadow_r.start_hold;
      end
      timing_pkg::ST_STOP_SETUP: begin
        // clock high, data low, clock periods
        phase_cond  = scl_in && !sda_in;
        phase_count = shadow_r.stop_setup;
      end
      timing_pkg::ST_STOP_HOLD: begin
        phase_cond  = scl_in && sda_in;
        phase_count = shadow_r.start_setup;
      end
      timing_pkg::ST_READY,
      timing_pkg::ST_BUSY: begin
        phase_cond  = 1'b1;
      end
    endcase
  end

  phase_counter u_phase (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .load    (phase_load_r),
    .tick    (phase_tick),
    .cond    (phase_cond),
    .count   (phase_count),
    .done    (phase_done)
  );

  // next-state decision
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      timing_pkg::ST_RESET_IDLE: begin
        if (phase_done) begin
          state_nxt = timing_pkg::ST_READY;
        end
      end
      timing_pkg::ST_READY: begin
        if (start_req) begin
          state_nxt = timing_pkg::ST_IDLE_CHECK;
        end
      end
      timing_pkg::ST_IDLE_CHECK: begin
        if (phase_done) begin
          state_nxt = timing_pkg::ST_START_SETUP;
        end
      end
      timing_pkg::ST_START_SETUP: begin
        if (phase_done) begin
          state_nxt = timing_pkg::ST_START_HOLD;
        end
      end
      timing_pkg::ST_START_HOLD: begin
        if (phase_done) begin
          state_nxt = timing_pkg::ST_BUSY;
        end
      end
      timing_pkg::ST_BUSY: begin
        if (stop_req) begin
          state_nxt = timing_pkg::ST_STOP_SETUP;
        end
      end
      timing_pkg::ST_STOP_SETUP: begin
        if (phase_done) begin
          state_nxt = timing_pkg::ST_STOP_HOLD;
        end
      end
      timing_pkg::ST_STOP_HOLD: begin
        if (phase_done) begin
          state_nxt = timing_pkg::ST_READY;
        end
      end
    endcase
  end

  // state register and phase-start pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_r      <= timing_pkg::ST_RESET_IDLE;
      phase_load_r <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      phase_load_r <= (state_nxt != state_r);
    end
  end

  // line drivers: low when enabled
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      unique case (state_nxt)
        timing_pkg::ST_START_HOLD: begin
          sda_oe <= 1'b1;
          scl_oe <= 1'b0;
        end
        timing_pkg::ST_BUSY: begin
          sda_oe <= 1'b1;
          scl_oe <= 1'b1;
        end
        timing_pkg::ST_STOP_SETUP: begin
          // clock released, data held low
          sda_oe <= 1'b1;
          scl_oe <= 1'b0;
        end
        timing_pkg::ST_RESET_IDLE,
        timing_pkg::ST_READY,
        timing_pkg::ST_IDLE_CHECK,
        timing_pkg::ST_START_SETUP,
        timing_pkg::ST_STOP_HOLD: begin
          sda_oe <= 1'b0;
          scl_oe <= 1'b0;
        end
      endcase
    end
  end

  // answers to the controller
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      start_done <= 1'b0;
      stop_done  <= 1'b0;
      bus_idle   <= 1'b0;
    end else begin
      start_done <= (state_r == timing_pkg::ST_START_HOLD) && (state_nxt == timing_pkg::ST_BUSY);
      stop_done  <= (state_r == timing_pkg::ST_STOP_HOLD) && (state_nxt == timing_pkg::ST_READY);
      bus_idle   <= (state_nxt == timing_pkg::ST_READY);
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        timing_pkg::OFF_DIVIDER:
          reg_rdata <= pack_pair(live_r.microsecond_divider, live_r.millisecond_divider);
        timing_pkg::OFF_START:
          reg_rdata <= pack_pair(live_r.start_setup, live_r.start_hold);
        timing_pkg::OFF_STOP_IDLE:
          reg_rdata <= pack_pair(live_r.stop_setup, live_r.bus_idle_detect_count);
        timing_pkg::OFF_STATUS: begin
          reg_rdata <= 32'h0000_0000;
          reg_rdata[timing_pkg::ST_BUS_IDLE]  <= bus_idle;
          reg_rdata[timing_pkg::ST_BOOT]      <= boot_active;
          reg_rdata[timing_pkg::ST_SHADOWED]  <= (live_r != shadow_r);
          reg_rdata[timing_pkg::ST_STATE_LSB +: 4] <= state_r;
        end
        default:
          reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : i2c_master_timing_base
`default_nettype wire

// ---- rtl/timing_pkg.sv ----
// package: register map, reset counts and state types of the two-wire timing core
package timing_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_DIVIDER    = 8'h00;
  localparam logic [7:0] OFF_START      = 8'h04;
  localparam logic [7:0] OFF_STOP_IDLE  = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;

  // field positions inside each 32-bit word
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;
  localparam int FIELD_W = 16;

  // status register bit positions
  localparam int ST_BUS_IDLE  = 0;
  localparam int ST_BOOT      = 1;
  localparam int ST_SHADOWED  = 2;
  localparam int ST_STATE_LSB = 4;

  // values after reset
  localparam logic [15:0] RST_US_DIV      = 16'h0063;
  localparam logic [15:0] RST_MS_DIV      = 16'h03E7;
  localparam logic [15:0] RST_START_SETUP = 16'h01D7;
  localparam logic [15:0] RST_START_HOLD  = 16'h0191;
  localparam logic [15:0] RST_STOP_SETUP  = 16'h0191;
  localparam logic [15:0] RST_IDLE_COUNT  = 16'h0033;

  // counter value of a phase that needs no waiting
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  // all programmable timing counts travel together
  typedef struct packed {
    logic [15:0] microsecond_divider;
    logic [15:0] millisecond_divider;
    logic [15:0] start_setup;
    logic [15:0] start_hold;
    logic [15:0] stop_setup;
    logic [15:0] bus_idle_detect_count;
  } timing_cfg_t;

  localparam timing_cfg_t CFG_RESET = '{
    microsecond_divider:   RST_US_DIV,
    millisecond_divider:   RST_MS_DIV,
    start_setup:           RST_START_SETUP,
    start_hold:            RST_START_HOLD,
    stop_setup:            RST_STOP_SETUP,
    bus_idle_detect_count: RST_IDLE_COUNT
  };

  // bus sequencing states
  typedef enum logic [3:0] {
    ST_RESET_IDLE,
    ST_READY,
    ST_IDLE_CHECK,
    ST_START_SETUP,
    ST_START_HOLD,
    ST_BUSY,
    ST_STOP_SETUP,
    ST_STOP_HOLD
  } bus_state_t;

endpackage : timing_pkg

// ---- rtl/tick_divider.sv ----
// tick_divider: one-cycle tick every (div + 1) enable pulses
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // rate control
  input  wire logic        en,
  input  wire logic [15:0] div,
  // tick out
  output var  logic        tick_r
);

  logic [15:0] cnt_r;

  // count enables, wrap after div
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (en) begin
        if (cnt_r >= div) begin
          cnt_r  <= 16'h0000;
          tick_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

endmodule : tick_divider
`default_nettype wire

// ---- rtl/phase_counter.sv ----
// phase_counter: loads a count, runs it down, done when empty and levels hold
`timescale 1ns/1ps
`default_nettype none
module phase_counter (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // control
  input  wire logic        load,
  input  wire logic        tick,
  input  wire logic        cond,
  input  wire logic [15:0] count,
  // result
  output logic             done
);

  logic [15:0] cnt_r;

  // reload on phase start or when the line levels drop
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
    end else if (load || !cond) begin
      cnt_r <= count;
    end else if (tick && (cnt_r != 16'h0000)) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  assign done = cond && !load && (cnt_r == 16'h0000);

endmodule : phase_counter
`default_nettype wire

// ---- test/two_wire_target.sv ----
// partner: pulled-up two-wire lines with a target that can stretch or disturb them
`timescale 1ns/1ps
`default_nettype none
module two_wire_target (
  // commands from the bench
  input  wire logic stretch,
  input  wire logic glitch,
  // device side
  input  wire logic scl_out,
  input  wire logic scl_oe,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  // resolved levels
  output wire logic scl_in,
  output wire logic sda_in
);
  // open drain with pull-up: low while any party pulls
  assign scl_in = (scl_oe ? scl_out : 1'b1) && !stretch;
  assign sda_in = (sda_oe ? sda_out : 1'b1) && !glitch;
endmodule : two_wire_target
`default_nettype wire

// ---- test/i2c_master_timing_base_sva.sv ----
// checker: port-level timing relations of the two-wire timing core
`timescale 1ns/1ps
`default_nettype none
module i2c_master_timing_base_sva (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // controller side
  input wire logic        boot_active,
  input wire logic        start_done,
  input wire logic        stop_done,
  input wire logic        bus_idle,
  input wire logic        us_tick,
  input wire logic        ms_tick,
  // lines
  input wire logic        scl_in,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_oe
);
  timing_pkg::timing_cfg_t live_r;
  logic [19:0] gap_r, ugap_r, hi2_r, sdl_r, stp_r, hiu_r, scu_r;
  logic        uok_r, mok_r, chg_r;
  wire logic   chg = boot_active || (reg_wr && reg_addr == timing_pkg::OFF_DIVIDER);
  // live copy of the programmed counts
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      live_r <= timing_pkg::CFG_RESET;
    end else if (reg_wr && reg_addr == timing_pkg::OFF_DIVIDER) begin
      live_r.microsecond_divider <= reg_wdata[15:0];
      live_r.millisecond_divider <= reg_wdata[31:16];
    end else if (reg_wr && reg_addr == timing_pkg::OFF_START) begin
      live_r.start_setup <= reg_wdata[15:0];
      live_r.start_hold  <= reg_wdata[31:16];
    end else if (reg_wr && reg_addr == timing_pkg::OFF_STOP_IDLE) begin
      live_r.stop_setup            <= reg_wdata[15:0];
      live_r.bus_idle_detect_count <= reg_wdata[31:16];
    end
  end
  // level run lengths and tick spacing; periods skipped around divider changes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      {gap_r, ugap_r, hi2_r, sdl_r, stp_r, hiu_r, scu_r} <= '0;
      {uok_r, mok_r, chg_r} <= '0;
    end else begin
      gap_r  <= us_tick ? 20'h1 : gap_r + 20'h1;
      ugap_r <= ms_tick ? 20'h0 : ugap_r + 20'(us_tick);
      hi2_r  <= (scl_in && sda_in) ? hi2_r + 20'h1 : 20'h0;
      sdl_r  <= sda_in ? 20'h0 : sdl_r + 20'h1;
      stp_r  <= (scl_in && !sda_in) ? stp_r + 20'h1 : 20'h0;
      hiu_r  <= (scl_in && sda_in) ? hiu_r + 20'(us_tick) : 20'h0;
      scu_r  <= scl_in ? scu_r + 20'(us_tick) : 20'h0;
      chg_r  <= chg;
      uok_r  <= !(chg || chg_r) && (uok_r || us_tick);
      mok_r  <= !(chg || chg_r) && (mok_r || ms_tick);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_sda_pull;
    $rose(sda_oe) && !scl_oe;
  endsequence
  property p_us_period;
    us_tick && uok_r |-> gap_r == 20'(live_r.microsecond_divider) + 20'h1;
  endproperty
  a_us_period: assert property (p_us_period) else $error("microsecond tick spacing wrong");
  property p_ms_period;
    ms_tick && mok_r |-> ugap_r + 20'(us_tick) == 20'(live_r.millisecond_divider) + 20'h1;
  endproperty
  a_ms_period: assert property (p_ms_period) else $error("millisecond tick spacing wrong");
  property p_start_setup;
    s_sda_pull |-> hi2_r + 20'h1 >= 20'(live_r.start_setup);
  endproperty
  a_start_setup: assert property (p_start_setup) else $error("data pulled before setup");
  property p_idle_check;
    s_sda_pull |-> hiu_r + 20'h1 >= 20'(live_r.bus_idle_detect_count);
  endproperty
  a_idle_check: assert property (p_idle_check) else $error("start without idle check");
  property p_start_hold;
    $rose(scl_oe) |-> start_done && sdl_r + 20'h1 >= 20'(live_r.start_hold);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("clock pulled before hold");
  property p_stop_setup;
    $fell(sda_oe) |-> stp_r + 20'h1 >= 20'(live_r.stop_setup);
  endproperty
  a_stop_setup: assert property (p_stop_setup) else $error("data released before stop setup");
  property p_stop_hold;
    stop_done |-> hi2_r + 20'h1 >= 20'(live_r.start_setup);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop done before stop hold");
  property p_reset_idle;
    $rose(bus_idle) |-> stop_done || $past(stop_done) || scu_r + 20'h1 >= 20'(live_r.bus_idle_detect_count);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("idle called too early");
  c_start: cover property (start_done);
  c_stop: cover property (stop_done);
  c_ms: cover property (ms_tick && mok_r);
endmodule : i2c_master_timing_base_sva
`default_nettype wire

// ---- test/i2c_master_timing_base_tb.sv ----
// testbench: registers, tick rates, boot freeze and start/stop timing
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module i2c_master_timing_base_tb;
  logic        sys_clk, rst_b, reg_wr, reg_rd, boot_active, start_req, stop_req, stretch, glitch;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, q;
  wire logic [31:0] reg_rdata;
  wire logic   start_done, stop_done, bus_idle, us_tick, ms_tick, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic [31:0] model [3];
  int          n_mismatch, checked, usd, msd, su, ho, sp, idl, n, ns;
  i2c_master_timing_base i2c_master_timing_base_i (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .boot_active, .start_req, .stop_req, .start_done, .stop_done, .bus_idle, .us_tick, .ms_tick,
    .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe);
  two_wire_target two_wire_target_i (.stretch, .glitch, .scl_out, .scl_oe, .sda_out, .sda_oe, .scl_in, .sda_in);
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // register cycle: write when w, else read into q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : bus
  task automatic set(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a < 8'h0C) model[a[3:2]] = d;
  endtask : set
  task automatic get(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    `CHK("reg_rdata", (a < 8'h0C) ? model[a[3:2]] : 32'h0, q)
  endtask : get
  // cycles between two ticks into n
  task automatic gap_of(input logic ms);
    n = 0;
    do @(posedge sys_clk); while (!(ms ? ms_tick : us_tick));
    do begin @(posedge sys_clk); n++; end while (!(ms ? ms_tick : us_tick));
  endtask : gap_of
  // start with optional data disturbance, stop with optional clock stretch
  task automatic xfer(input logic g, input logic s);
    @(posedge sys_clk);
    start_req <= 1'b1;
    @(posedge sys_clk);
    start_req <= 1'b0;
    glitch    <= g;
    @(posedge sys_clk);
    glitch <= 1'b0;
    for (ns = 2; start_done !== 1'b1 && ns < 9999; ns++) @(posedge sys_clk);
    `CHK("start_time", 1'b1, ns >= su + ho && ns <= 2 * idl * (usd + 1) + su + ho + 20)
    `CHK("start_oe", 2'b11, {scl_oe, sda_oe})
    @(posedge sys_clk);
    stop_req <= 1'b1;
    stretch  <= s;
    @(posedge sys_clk);
    stop_req <= 1'b0;
    repeat (30) @(posedge sys_clk);
    stretch <= 1'b0;
    for (n = 31; stop_done !== 1'b1 && n < 9999; n++) @(posedge sys_clk);
    `CHK("stop_time", 1'b1, n >= sp + su && n <= sp + su + (s ? 30 : 0) + 20)
    @(posedge sys_clk);
    #1;
    `CHK("after_stop", 4'h8, {bus_idle, stop_done, scl_oe, sda_oe})
  endtask : xfer
  task automatic stop_test();
    $display("compared %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, boot_active, start_req, stop_req, stretch, glitch} = '0;
    {reg_addr, reg_wdata, n_mismatch, checked} = '0;
    model = '{{timing_pkg::RST_MS_DIV, timing_pkg::RST_US_DIV}, {timing_pkg::RST_START_HOLD,
      timing_pkg::RST_START_SETUP}, {timing_pkg::RST_IDLE_COUNT, timing_pkg::RST_STOP_SETUP}};
    void'($urandom(32'h248737d7));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 12; a += 4) get(8'(a));
    usd = 1 + $urandom % 4;
    msd = 2 + $urandom % 4;
    su  = 20 + $urandom % 20;
    ho  = 10 + $urandom % 20;
    sp  = 20 + $urandom % 20;
    idl = 2 + $urandom % 4;
    set(timing_pkg::OFF_DIVIDER, {16'(msd), 16'(usd)});
    set(timing_pkg::OFF_START, {16'(ho), 16'(su)});
    set(timing_pkg::OFF_STOP_IDLE, {16'(idl), 16'(sp)});
    set(8'h10, 32'hFFFFFFFF);
    for (int a = 0; a < 20; a += 4) if (a != 12) get(8'(a));
    for (n = 0; bus_idle !== 1'b1 && n < 8000; n++) @(posedge sys_clk);
    `CHK("bus_idle", 1'b1, bus_idle)
    gap_of(1'b0);
    `CHK("us_period", usd + 1, n)
    gap_of(1'b1);
    `CHK("ms_period", (msd + 1) * (usd + 1), n)
    boot_active <= 1'b1;
    set(timing_pkg::OFF_DIVIDER, {16'(msd), 16'(usd + 2)});
    bus(1'b0, timing_pkg::OFF_STATUS, 32'h0);
    `CHK("status_boot", 2'b11, q[timing_pkg::ST_SHADOWED:timing_pkg::ST_BOOT])
    // stop setup halved during boot must not shorten the stop yet
    set(timing_pkg::OFF_STOP_IDLE, {16'(idl), 16'(sp / 2)});
    xfer(1'b0, 1'b0);
    gap_of(1'b0);
    `CHK("us_frozen", usd + 1, n)
    boot_active <= 1'b0;
    usd = usd + 2;
    sp  = sp / 2;
    repeat (4) @(posedge sys_clk);
    gap_of(1'b0);
    `CHK("us_applied", usd + 1, n)
    xfer(1'b0, 1'b0);
    xfer(1'b1, 1'b1);
    idl = 0;
    set(timing_pkg::OFF_STOP_IDLE, {16'h0000, 16'(sp)});
    xfer(1'b0, 1'b0);
    `CHK("idle_zero", 1'b1, ns <= su + ho + 20)
    stop_test();
  end
endmodule : i2c_master_timing_base_tb
bind i2c_master_timing_base i2c_master_timing_base_sva sva_i (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .boot_active, .start_done, .stop_done, .bus_idle, .us_tick, .ms_tick, .scl_in, .scl_oe, .sda_in, .sda_oe);
`default_nettype wire
